// file: inc/ufc_defines.svh
// constants for the uart fifo level and flow control block
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH

// ************************************************************
// register offsets
// ************************************************************
`define UFC_ADDR_TX_LEVEL 5'h11
`define UFC_ADDR_RX_LEVEL 5'h12
`define UFC_ADDR_FLOW_CFG 5'h13
`define UFC_ADDR_RESUME1  5'h14

// ************************************************************
// reset values and sizes
// ************************************************************
`define UFC_BYTE_RESET    8'h00
`define UFC_FIFO_DEPTH    8'h80
`define UFC_COUNT_STEP    8'h01
`define UFC_THR_SHIFT     3
`define UFC_SEL_NONE      2'h0
`define UFC_SEL_PRIMARY   2'h2
`define UFC_SEL_SECONDARY 2'h1
`define UFC_SEL_ALL       2'h3

`endif

// file: inc/ufc_pkg.sv
// types shared by the uart fifo level and flow control block
package ufc_pkg;

  // flow_control_config layout, msb first as in the register
  typedef struct packed {
    logic [1:0] gen_select;           // chars sent for receiver flow control
    logic [1:0] cmp_select;           // chars compared on receive
    logic       soft_flow_enable;     // automatic xon/xoff
    logic       gpio_address_enable;  // gpio inputs form special char low nibble
    logic       auto_clear_to_send;   // transmitter follows cts
    logic       auto_request_to_send; // rts follows rx fill level
  } ufc_cfg_type;

  // flow_threshold_register layout
  typedef struct packed {
    logic [3:0] resume;  // resume level in units of eight words
    logic [3:0] halt;    // halt level in units of eight words
  } ufc_level_type;

  // three of the four flow control characters, the primary resume is a register
  typedef struct packed {
    logic [7:0] resume_sec;
    logic [7:0] halt_pri;
    logic [7:0] halt_sec;
  } ufc_chars_type;

endpackage

// file: logic/ufc_flow.sv
// fifo fill level reporting and automatic flow control of a uart
// Notes on behaviour
// - tx level register reports tx fifo words
// - rx level register reports rx fifo words
// - soft flow enable turns on xon/xoff control
// - received flow chars dropped only when generating
// - special detect without soft flow: no tx control
// - both on: primary flow, secondary special
// - gpio address: special low nibble from gpio
// - gpio address ignores halt secondary low nibble
// - auto cts stops and resumes the transmitter
// - any cts change raises the cts interrupt
// - auto rts follows rx fill thresholds
// - upper select bits choose generated characters
// - lower select bits choose compared characters
// - all select bits zero: no detection at all
// - primary resume register, eight bits, resets zero
// - thresholds are eight times the field
// - double char: primary low byte, secondary high
`timescale 1ns/1ps
`include "ufc_defines.svh"

module ufc_flow (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  // register port
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [4:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata_q,
  // fifo traffic
  input  wire logic                  tx_push,
  input  wire logic                  tx_pop,
  input  wire logic                  rx_pop,
  // receiver output before filtering
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_char,
  output logic                       rx_store_q,
  output logic      [7:0]            rx_store_data_q,
  output logic                       special_hit_q,
  // settings held elsewhere in the uart
  input  wire ufc_pkg::ufc_chars_type chars,
  input  wire ufc_pkg::ufc_level_type flow_threshold_register,
  input  wire logic                  special_detect_en,
  input  wire logic [3:0]            gpio_in,
  // modem lines and transmitter control
  input  wire logic                  cts_n,
  output logic                       tx_stop_q,
  output logic                       rts_n_q,
  output logic                       cts_change_irq_q,
  output logic                       send_halt_q,
  output logic                       send_resume_q,
  output logic      [15:0]           resume_word_q,
  output logic      [15:0]           halt_word_q
);

  // ************************************************************
  // state
  // ************************************************************
  ufc_pkg::ufc_cfg_type cfg_q, cfg_d;       // flow_control_config
  logic [7:0] resume_char_primary_q, resume_char_primary_d;
  logic [7:0] tx_level_q, tx_level_d;       // tx_fifo_fill_count
  logic [7:0] rx_level_q, rx_level_d;       // rx_fifo_fill_count
  logic [7:0] rdata_d;
  logic       rx_store_d, special_hit_d;
  logic [7:0] rx_store_data_d;
  logic       xoff_seen_q, xoff_seen_d;     // far end told us to halt
  logic       far_halted_q, far_halted_d;   // we told far end to halt
  logic       cts_last_q, cts_last_d;
  logic       tx_stop_d, rts_n_d, cts_irq_d;
  logic       send_halt_d, send_resume_d;
  logic [15:0] resume_word_d, halt_word_d;

  // ************************************************************
  // helpers
  // ************************************************************
  // threshold in words from a four bit field
  function automatic logic [7:0] thr(input logic [3:0] f);
    thr = 8'(f) << `UFC_THR_SHIFT;
  endfunction

  logic [7:0] halt_thr, resume_thr, halt2_eff;
  logic       flow_p, flow_s, sp_p, sp_s;
  logic       hit_halt, hit_resume, hit_special, rx_fc_on, tx_fc_on;
  logic       tx_inc, tx_dec, rx_inc, rx_dec;

  // ************************************************************
  // character matching
  // ************************************************************
  always_comb begin
    halt_thr   = thr(flow_threshold_register.halt);
    resume_thr = thr(flow_threshold_register.resume);
    // low nibble from gpio, stored nibble neglected
    halt2_eff = cfg_q.gpio_address_enable ?
                {chars.halt_sec[7:4], gpio_in} : chars.halt_sec;
    // with both enables the pairs split between the two uses
    flow_p = cfg_q.soft_flow_enable & cfg_q.cmp_select[1];
    flow_s = cfg_q.soft_flow_enable & ~special_detect_en & cfg_q.cmp_select[0];
    sp_p   = special_detect_en & ~cfg_q.soft_flow_enable & cfg_q.cmp_select[1];
    sp_s   = special_detect_en & cfg_q.cmp_select[0];
    hit_halt    = (flow_p & (rx_char == chars.halt_pri)) |
                  (flow_s & (rx_char == halt2_eff));
    hit_resume  = (flow_p & (rx_char == resume_char_primary_q)) |
                  (flow_s & (rx_char == chars.resume_sec));
    hit_special = (sp_p & ((rx_char == resume_char_primary_q) | (rx_char == chars.halt_pri))) |
                  (sp_s & ((rx_char == chars.resume_sec) | (rx_char == halt2_eff)));
    rx_fc_on = cfg_q.soft_flow_enable & (cfg_q.gen_select != `UFC_SEL_NONE);
    tx_fc_on = cfg_q.soft_flow_enable;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    cfg_d                 = cfg_q;
    resume_char_primary_d = resume_char_primary_q;
    // register writes, read-only offsets ignore the write
    if (reg_wr) begin
      case (reg_addr)
        `UFC_ADDR_FLOW_CFG: cfg_d = ufc_pkg::ufc_cfg_type'(reg_wdata);
        `UFC_ADDR_RESUME1:  resume_char_primary_d = reg_wdata;
        default: ;
      endcase
    end
    // registered read data, unmapped reads as zero
    rdata_d = reg_rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        `UFC_ADDR_TX_LEVEL: rdata_d = tx_level_q;
        `UFC_ADDR_RX_LEVEL: rdata_d = rx_level_q;
        `UFC_ADDR_FLOW_CFG: rdata_d = cfg_q;
        `UFC_ADDR_RESUME1:  rdata_d = resume_char_primary_q;
        default:            rdata_d = `UFC_BYTE_RESET;
      endcase
    end
    // receive filter: flow chars dropped only when we generate them
    rx_store_d      = rx_valid & ~(rx_fc_on & (hit_halt | hit_resume));
    rx_store_data_d = rx_char;
    special_hit_d   = rx_valid & hit_special;
    // level counters, blocked pushes at full and pops at empty
    tx_inc = tx_push & (tx_level_q != `UFC_FIFO_DEPTH);
    tx_dec = tx_pop & (tx_level_q != `UFC_BYTE_RESET);
    rx_inc = rx_store_d & (rx_level_q != `UFC_FIFO_DEPTH);
    rx_dec = rx_pop & (rx_level_q != `UFC_BYTE_RESET);
    tx_level_d = tx_level_q;
    if (tx_inc & ~tx_dec) begin
      tx_level_d = tx_level_q + `UFC_COUNT_STEP;
    end else if (tx_dec & ~tx_inc) begin
      tx_level_d = tx_level_q - `UFC_COUNT_STEP;
    end
    rx_level_d = rx_level_q;
    if (rx_inc & ~rx_dec) begin
      rx_level_d = rx_level_q + `UFC_COUNT_STEP;
    end else if (rx_dec & ~rx_inc) begin
      rx_level_d = rx_level_q - `UFC_COUNT_STEP;
    end
    // received xoff halts our transmitter, xon resumes it
    xoff_seen_d = xoff_seen_q;
    if (!tx_fc_on) begin
      xoff_seen_d = 1'b0;
    end else if (rx_valid & hit_halt) begin
      xoff_seen_d = 1'b1;
    end else if (rx_valid & hit_resume) begin
      xoff_seen_d = 1'b0;
    end
    // cts: any level change is an event
    cts_last_d = cts_n;
    cts_irq_d  = cts_n != cts_last_q;
    tx_stop_d  = (cfg_q.auto_clear_to_send & cts_n) | xoff_seen_q;
    // rts: halt level wins if both thresholds are met
    rts_n_d = rts_n_q;
    if (!cfg_q.auto_request_to_send) begin
      rts_n_d = 1'b0;
    end else if (rx_level_q >= halt_thr) begin
      rts_n_d = 1'b1;
    end else if (rx_level_q <= resume_thr) begin
      rts_n_d = 1'b0;
    end
    // xoff/xon requests towards the transmitter
    send_halt_d   = 1'b0;
    send_resume_d = 1'b0;
    far_halted_d  = far_halted_q;
    if (!rx_fc_on) begin
      far_halted_d = 1'b0;
    end else if (!far_halted_q && rx_level_q >= halt_thr) begin
      send_halt_d  = 1'b1;
      far_halted_d = 1'b1;
    end else if (far_halted_q && rx_level_q <= resume_thr) begin
      send_resume_d = 1'b1;
      far_halted_d  = 1'b0;
    end
    // characters the transmitter sends, double pair primary low
    case (cfg_q.gen_select)
      `UFC_SEL_PRIMARY: begin
        resume_word_d = {`UFC_BYTE_RESET, resume_char_primary_q};
        halt_word_d   = {`UFC_BYTE_RESET, chars.halt_pri};
      end
      `UFC_SEL_SECONDARY: begin
        resume_word_d = {`UFC_BYTE_RESET, chars.resume_sec};
        halt_word_d   = {`UFC_BYTE_RESET, chars.halt_sec};
      end
      `UFC_SEL_ALL: begin
        resume_word_d = {chars.resume_sec, resume_char_primary_q};
        halt_word_d   = {chars.halt_sec, chars.halt_pri};
      end
      default: begin
        resume_word_d = {`UFC_BYTE_RESET, `UFC_BYTE_RESET};
        halt_word_d   = {`UFC_BYTE_RESET, `UFC_BYTE_RESET};
      end
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  // synchronous reset clears everything to its documented value except cts_last_q, which loads cts_n
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_q                 <= ufc_pkg::ufc_cfg_type'(`UFC_BYTE_RESET);
      resume_char_primary_q <= `UFC_BYTE_RESET;
      tx_level_q            <= `UFC_BYTE_RESET;
      rx_level_q            <= `UFC_BYTE_RESET;
      reg_rdata_q           <= `UFC_BYTE_RESET;
      rx_store_q            <= 1'b0;
      rx_store_data_q       <= `UFC_BYTE_RESET;
      special_hit_q         <= 1'b0;
      xoff_seen_q           <= 1'b0;
      far_halted_q          <= 1'b0;
      cts_last_q            <= cts_n; // follow the pin so release shows no false change
      cts_change_irq_q      <= 1'b0;
      tx_stop_q             <= 1'b0;
      rts_n_q               <= 1'b0;
      send_halt_q           <= 1'b0;
      send_resume_q         <= 1'b0;
      resume_word_q         <= {`UFC_BYTE_RESET, `UFC_BYTE_RESET};
      halt_word_q           <= {`UFC_BYTE_RESET, `UFC_BYTE_RESET};
    end else begin
      cfg_q                 <= cfg_d;
      resume_char_primary_q <= resume_char_primary_d;
      tx_level_q            <= tx_level_d;
      rx_level_q            <= rx_level_d;
      reg_rdata_q           <= rdata_d;
      rx_store_q            <= rx_store_d;
      rx_store_data_q       <= rx_store_data_d;
      special_hit_q         <= special_hit_d;
      xoff_seen_q           <= xoff_seen_d;
      far_halted_q          <= far_halted_d;
      cts_last_q            <= cts_last_d;
      cts_change_irq_q      <= cts_irq_d;
      tx_stop_q             <= tx_stop_d;
      rts_n_q               <= rts_n_d;
      send_halt_q           <= send_halt_d;
      send_resume_q         <= send_resume_d;
      resume_word_q         <= resume_word_d;
      halt_word_q           <= halt_word_d;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  tx_level_cap_a: assert property (tx_level_q <= `UFC_FIFO_DEPTH)
    else $error("tx level above fifo depth");
  rx_level_cap_a: assert property (rx_level_q <= `UFC_FIFO_DEPTH)
    else $error("rx level above fifo depth");
  tx_count_up_a: assert property (tx_push && !tx_pop && tx_level_q < `UFC_FIFO_DEPTH
    |=> tx_level_q == $past(tx_level_q) + `UFC_COUNT_STEP)
    else $error("tx level did not count a push");
  rx_read_level_a: assert property (reg_rd && reg_addr == `UFC_ADDR_RX_LEVEL
    |=> reg_rdata_q == $past(rx_level_q))
    else $error("rx level read wrong");
  flow_drop_a: assert property (rx_valid && rx_fc_on && hit_halt |=> !rx_store_q)
    else $error("flow char stored");
  no_select_a: assert property (rx_valid && cfg_q[7:4] == 4'h0
    |=> rx_store_q && !special_hit_q)
    else $error("detection with no chars selected");
  gpio_special_a: assert property (rx_valid && cfg_q.gpio_address_enable && special_detect_en
    && cfg_q.cmp_select[0] && rx_char == {chars.halt_sec[7:4], gpio_in} |=> special_hit_q)
    else $error("gpio special char missed");
  // one pulse per change of the pin, and none without a change
  cts_irq_a: assert property (cts_n != cts_last_q |=> cts_change_irq_q)
    else $error("cts change not flagged");
  cts_quiet_a: assert property (cts_n == cts_last_q |=> !cts_change_irq_q)
    else $error("cts pulse without a change");
  cts_stop_a: assert property (cfg_q.auto_clear_to_send && cts_n |=> tx_stop_q)
    else $error("transmitter not stopped by cts");
  rts_halt_a: assert property (cfg_q.auto_request_to_send && rx_level_q >= halt_thr |=> rts_n_q)
    else $error("rts not raised at halt level");
  rts_release_a: assert property ((!cfg_q.auto_request_to_send ||
    (rx_level_q < halt_thr && rx_level_q <= resume_thr)) |=> !rts_n_q)
    else $error("rts not released");
  halt_send_a: assert property (rx_fc_on && !far_halted_q && rx_level_q >= halt_thr |=> send_halt_q)
    else $error("halt request not sent");
  xoff_stop_a: assert property (tx_fc_on && rx_valid && hit_halt |=> ##1 tx_stop_q)
    else $error("received halt did not stop transmitter");

endmodule

// file: testbench/ufc_flow_tb.sv
// self-checking bench for the fifo level and flow control block
`timescale 1ns/1ps
`include "ufc_defines.svh"

module ufc_flow_tb;
  // ************************************************************
  // signals
  // ************************************************************
  typedef struct packed {
    logic [4:0] addr;  // register offset
    logic       wr;    // write before reading back
    logic [7:0] wdata; // value written
    logic [7:0] exp;   // value read back
  } ufc_row_type;
  logic                   clk_sys, sys_rst, reg_wr, reg_rd, tx_push, tx_pop, rx_pop;
  logic                   rx_valid, rx_store_q, special_hit_q, special_detect_en, cts_n;
  logic                   tx_stop_q, rts_n_q, cts_change_irq_q, send_halt_q, send_resume_q;
  logic [4:0]             reg_addr;
  logic [7:0]             reg_wdata, reg_rdata_q, rx_char, rx_store_data_q, rd_val;
  logic [3:0]             gpio_in;
  logic [15:0]            resume_word_q, halt_word_q, halt_seen, resume_seen, exp_h, exp_r;
  ufc_pkg::ufc_chars_type chars;
  ufc_pkg::ufc_level_type flow_threshold_register;
  int                     fails, num_checks, n_halt, n_resume;
  // reset values, write-back, read-only and unmapped places
  ufc_row_type            rows [9] = '{
    {`UFC_ADDR_TX_LEVEL, 1'b0, 8'h00, 8'h00}, {`UFC_ADDR_RX_LEVEL, 1'b0, 8'h00, 8'h00},
    {`UFC_ADDR_FLOW_CFG, 1'b0, 8'h00, 8'h00}, {`UFC_ADDR_RESUME1, 1'b0, 8'h00, 8'h00},
    {`UFC_ADDR_FLOW_CFG, 1'b1, 8'ha5, 8'ha5}, {`UFC_ADDR_RESUME1, 1'b1, 8'h3c, 8'h3c},
    {`UFC_ADDR_TX_LEVEL, 1'b1, 8'hff, 8'h00}, {`UFC_ADDR_RX_LEVEL, 1'b1, 8'hff, 8'h00},
    {5'h1f, 1'b1, 8'hff, 8'h00}};

  ufc_flow u_ufc_flow (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .tx_push(tx_push),
    .tx_pop(tx_pop), .rx_pop(rx_pop), .rx_valid(rx_valid), .rx_char(rx_char), .rx_store_q(rx_store_q),
    .rx_store_data_q(rx_store_data_q), .special_hit_q(special_hit_q), .chars(chars),
    .flow_threshold_register(flow_threshold_register), .special_detect_en(special_detect_en),
    .gpio_in(gpio_in), .cts_n(cts_n), .tx_stop_q(tx_stop_q), .rts_n_q(rts_n_q),
    .cts_change_irq_q(cts_change_irq_q), .send_halt_q(send_halt_q), .send_resume_q(send_resume_q),
    .resume_word_q(resume_word_q), .halt_word_q(halt_word_q));
  ufc_remote_model u_ufc_remote_model (.clk_sys(clk_sys), .rts_n(rts_n_q), .rx_valid(rx_valid),
    .rx_char(rx_char));

  // 200 mhz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // latch flow character requests, they stand for one cycle only
  always @(posedge clk_sys) begin
    if (send_halt_q === 1'b1) begin
      n_halt++;
      halt_seen = halt_word_q;
    end
    if (send_resume_q === 1'b1) begin
      n_resume++;
      resume_seen = resume_word_q;
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1 reg_wr = 1'b0;
  endtask

  // read data is registered at the strobe edge
  task automatic rd(input logic [4:0] a);
    @(posedge clk_sys);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1 reg_rd = 1'b0;
    rd_val = reg_rdata_q;
  endtask

  task automatic tx_ops(input logic pu, input logic po, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1 tx_push = pu;
      tx_pop = po;
    end
    @(posedge clk_sys);
    #1 tx_push = 1'b0;
    tx_pop = 1'b0;
  endtask

  task automatic rx_pops(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1 rx_pop = 1'b1;
    end
    @(posedge clk_sys);
    #1 rx_pop = 1'b0;
  endtask

  // one character in, store and detect outputs one cycle later
  task automatic rx_chk(input logic [7:0] ch, input logic st, input logic hit);
    u_ufc_remote_model.send(ch);
    check(rx_store_q, st, "store");
    if (st) check(rx_store_data_q, ch, "stored data");
    check(special_hit_q, hit, "special");
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog, the whole run needs well under a thousand cycles
  initial begin
    #100us;
    fails++;
    $display("ERROR t=%0t watchdog expired", $time);
    summarize();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {sys_rst, reg_wr, reg_rd, tx_push, tx_pop, rx_pop, special_detect_en, cts_n} = 8'h80;
    {reg_addr, reg_wdata, gpio_in} = 17'h00000;
    chars = {8'h12, 8'h13, 8'h5a};
    flow_threshold_register = {4'h1, 4'h2};
    {fails, num_checks, n_halt, n_resume} = '0;
    repeat (10) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr);
      check(rd_val, rows[i].exp, "register row");
    end
    // level counting, both at once leaves it alone, saturates at depth
    tx_ops(1, 0, 3);
    tx_ops(1, 1, 2);
    tx_ops(0, 1, 1);
    rd(`UFC_ADDR_TX_LEVEL);
    check(rd_val, 8'h02, "tx level");
    tx_ops(1, 0, 130);
    rd(`UFC_ADDR_TX_LEVEL);
    check(rd_val, `UFC_FIFO_DEPTH, "tx full");
    tx_ops(0, 1, 130);
    rd(`UFC_ADDR_TX_LEVEL);
    check(rd_val, 8'h00, "tx empty");
    // primary pair flow control, unmatched data passes
    wr(`UFC_ADDR_RESUME1, 8'h11);
    wr(`UFC_ADDR_FLOW_CFG, 8'ha8);
    rx_chk(8'h13, 0, 0);
    @(posedge clk_sys);
    #1 check(tx_stop_q, 1'b1, "halted");
    rx_chk(8'h41, 1, 0);
    rx_chk(8'h11, 0, 0);
    @(posedge clk_sys);
    #1 check(tx_stop_q, 1'b0, "resumed");
    rd(`UFC_ADDR_RX_LEVEL);
    check(rd_val, 8'h01, "rx level");
    wr(`UFC_ADDR_FLOW_CFG, 8'h08);
    rx_chk(8'h13, 1, 0);
    special_detect_en = 1'b1;
    wr(`UFC_ADDR_FLOW_CFG, 8'h10);
    rx_chk(8'h5a, 1, 1);
    check(tx_stop_q, 1'b0, "no tx flow");
    wr(`UFC_ADDR_FLOW_CFG, 8'hb8);
    rx_chk(8'h13, 0, 0);
    rx_chk(8'h5a, 1, 1);
    rx_chk(8'h11, 0, 0);
    // gpio levels replace the low nibble of the secondary halt
    gpio_in = 4'h3;
    wr(`UFC_ADDR_FLOW_CFG, 8'h14);
    rx_chk(8'h53, 1, 1);
    rx_chk(8'h5a, 1, 0);
    special_detect_en = 1'b0;
    rx_pops(10);
    rd(`UFC_ADDR_RX_LEVEL);
    check(rd_val, 8'h00, "rx drained");
    // cts edges raise the change pulse, stop only with auto cts
    for (int c = 0; c < 2; c++) begin
      wr(`UFC_ADDR_FLOW_CFG, {6'h00, c[0], 1'b0});
      cts_n = 1'b1;
      @(posedge clk_sys);
      #1 check(cts_change_irq_q, 1'b1, "cts rise");
      check(tx_stop_q, c[0], "cts stop");
      @(posedge clk_sys);
      #1 check(cts_change_irq_q, 1'b0, "cts pulse");
      cts_n = 1'b0;
      @(posedge clk_sys);
      #1 check(cts_change_irq_q, 1'b1, "cts fall");
      check(tx_stop_q, 1'b0, "cts go");
    end
    // fill to halt at 16, drain to resume at 8, per generated set
    for (int g = 1; g < 4; g++) begin
      wr(`UFC_ADDR_FLOW_CFG, {g[1:0], 6'h09});
      exp_h = (g == 3) ? {chars.halt_sec, chars.halt_pri} : {8'h00, g[1] ? chars.halt_pri : chars.halt_sec};
      exp_r = (g == 3) ? {chars.resume_sec, 8'h11} : {8'h00, g[1] ? 8'h11 : chars.resume_sec};
      {n_halt, n_resume} = '0;
      repeat (16) u_ufc_remote_model.send(8'h41);
      repeat (3) @(posedge clk_sys);
      #1 check(n_halt, 16'h1, "halt sent");
      check(halt_seen, exp_h, "halt word");
      check(rts_n_q, 1'b1, "rts halt");
      rd(`UFC_ADDR_RX_LEVEL);
      check(rd_val, 8'h10, "rx level");
      rx_pops(8);
      repeat (3) @(posedge clk_sys);
      #1 check(n_resume, 16'h1, "resume sent");
      check(resume_seen, exp_r, "resume word");
      check(rts_n_q, 1'b0, "rts go");
      rx_pops(8);
    end
    // second reset clears levels and configuration
    tx_ops(1, 0, 5);
    wr(`UFC_ADDR_FLOW_CFG, 8'hff);
    sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    @(posedge clk_sys);
    #1 check(cts_change_irq_q, 1'b0, "no cts pulse after reset");
    rd(`UFC_ADDR_TX_LEVEL);
    check(rd_val, 8'h00, "tx after reset");
    rd(`UFC_ADDR_FLOW_CFG);
    check(rd_val, 8'h00, "cfg after reset");
    rd(`UFC_ADDR_RESUME1);
    check(rd_val, 8'h00, "resume after reset");
    summarize();
  end
endmodule

// file: testbench/ufc_remote_model.sv
// far end serial station feeding characters into the receive filter
`timescale 1ns/1ps

module ufc_remote_model (
  input  wire logic       clk_sys,
  input  wire logic       rts_n,
  output logic            rx_valid,
  output logic      [7:0] rx_char
);
  // line idles with no character offered
  initial begin
    rx_valid = 1'b0;
    rx_char  = 8'h00;
  end

  // one character, offered just after an edge for one cycle
  task automatic send(input logic [7:0] ch);
    @(posedge clk_sys);
    while (rts_n) begin
      @(posedge clk_sys);
    end
    #1 rx_valid = 1'b1;
    rx_char = ch;
    @(posedge clk_sys);
    #1 rx_valid = 1'b0;
    // stale data must not look like the last character
    rx_char = ~ch;
  endtask
endmodule
